//--- rtl/sbs_sequencer.sv
// bus sequencer for trap, interrupt-wait, return, sleep and branch groups
`timescale 1ns/10ps
module sbs_sequencer
  import sbs_pkg::*;
(
  // clock and resets
  input wire logic clk,
  input wire logic reset,
  input wire logic power_on_clear_n,
  input wire logic osc_running,
  // instruction issue from the core
  input wire logic start,
  input wire logic [2:0] op_kind,
  input wire logic [15:0] op_addr,
  input wire logic [15:0] stack_ptr,
  input wire logic branch_taken,
  // register values to stack
  input wire logic [15:0] index_reg,
  input wire logic [7:0] acc_a,
  input wire logic [7:0] acc_b,
  input wire logic [7:0] flags,
  // wake events
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic wake_req,
  // external bus
  input wire logic [7:0] data_in,
  input wire logic wo_hit,
  output logic [15:0] addr_ff,
  output logic rw_ff,
  output logic rd_n_ff,
  output logic wr_n_ff,
  output logic opcode_fetch_n_ff,
  output logic [7:0] dout_ff,
  // results to the core
  output logic [7:0] rd_data_ff,
  output logic rd_valid_ff,
  output logic busy,
  output logic done,
  output logic waiting,
  output logic sleeping
);
  logic clr; // combined internal clear
  sbs_state_t state_ff; // cycle now on the bus
  sbs_state_t nxt_state;
  logic [2:0] cnt_ff; // byte index in stack or pull run
  logic [2:0] nxt_cnt;
  sbs_op_t kind_ff; // latched instruction group
  logic [15:0] pc_ff; // latched opcode address
  logic [15:0] sp_ff; // latched stack pointer
  logic taken_ff; // latched branch condition
  logic [15:0] target_ff; // address of the closing opcode fetch
  logic [15:0] nxt_target;
  logic [15:0] vec_ff; // vector pair address
  logic [15:0] nxt_vec;
  logic [15:0] ret_addr; // return address to stack
  logic [15:0] nxt_addr;
  logic nxt_rw;
  logic nxt_lir_n;
  logic [7:0] nxt_dout;
  logic [15:0] rel_target; // pc plus 2 plus signed offset
  logic [7:0] rd_byte; // read byte as the core sees it

  // clear pin handling lives in its own module
  sbs_clear_sync u_clear (
    .clk(clk),
    .reset(reset),
    .power_on_clear_n(power_on_clear_n),
    .osc_running(osc_running),
    .internal_clear(clr)
  );

  // picks the byte for stack slot k of the frame
  function automatic logic [7:0] frame_byte(input logic [2:0] k, input logic [15:0] ret,
                                            input logic [15:0] ix, input logic [7:0] a,
                                            input logic [7:0] b, input logic [7:0] cc);
    case (k)
      3'h0: frame_byte = ret[7:0];
      3'h1: frame_byte = ret[15:8];
      3'h2: frame_byte = ix[7:0];
      3'h3: frame_byte = ix[15:8];
      3'h4: frame_byte = a;
      3'h5: frame_byte = b;
      default: frame_byte = cc;
    endcase
  endfunction : frame_byte

  // subroutine branch returns past its offset; traps return past the opcode
  assign ret_addr = (kind_ff == OP_BR_SUB) ? pc_ff + 16'h0002 : pc_ff + 16'h0001;
  assign rd_byte = wo_hit ? WO_READ_VALUE : data_in;
  assign rel_target = pc_ff + 16'h0002 + {{8{rd_byte[7]}}, rd_byte};

  // next cycle selection
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_target = target_ff;
    nxt_vec = vec_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start) begin
          nxt_state = ST_FETCH1;
        end
      end
      ST_FETCH1: begin
        // offset byte is on data_in now
        nxt_state = ST_DUMMY;
        if (kind_ff == OP_BRANCH) begin
          nxt_target = taken_ff ? rel_target : pc_ff + 16'h0002;
        end else if (kind_ff == OP_BR_SUB) begin
          nxt_target = rel_target;
        end
      end
      ST_DUMMY: begin
        nxt_cnt = CNT_RST;
        case (kind_ff)
          OP_IDLE_IRQ, OP_SOFT_TRAP, OP_BR_SUB: nxt_state = ST_STACK;
          OP_RET_IRQ: nxt_state = ST_PULL;
          OP_SLEEP: nxt_state = ST_SLEEP;
          default: nxt_state = ST_OPFETCH;
        endcase
      end
      ST_STACK: begin
        if (kind_ff == OP_BR_SUB && cnt_ff == SUB_FRAME_LAST) begin
          nxt_state = ST_OPFETCH;
        end else if (cnt_ff == FULL_FRAME_LAST) begin
          if (kind_ff == OP_SOFT_TRAP) begin
            nxt_state = ST_VEC_HI;
            nxt_vec = TRAP_VEC_HI;
          end else begin
            nxt_state = ST_WAIT_IRQ;
          end
        end else begin
          nxt_cnt = cnt_ff + 3'h1;
        end
      end
      ST_PULL: begin
        // restored return address feeds the closing fetch
        if (cnt_ff == PULL_RET_HI_IDX) begin
          nxt_target = {rd_byte, target_ff[7:0]};
        end
        if (cnt_ff == PULL_RET_LO_IDX) begin
          nxt_target = {target_ff[15:8], rd_byte};
          nxt_state = ST_OPFETCH;
        end else begin
          nxt_cnt = cnt_ff + 3'h1;
        end
      end
      ST_WAIT_IRQ: begin
        // frame already stacked, so go straight to the vector
        if (irq_req) begin
          nxt_state = ST_VEC_HI;
          nxt_vec = irq_vector;
        end
      end
      ST_VEC_HI: begin
        nxt_target = {rd_byte, target_ff[7:0]};
        nxt_state = ST_VEC_LO;
      end
      ST_VEC_LO: begin
        nxt_target = {target_ff[15:8], rd_byte};
        nxt_state = ST_OPFETCH;
      end
      ST_SLEEP: begin
        if (wake_req) begin
          nxt_state = ST_WAKE_DUMMY;
        end
      end
      ST_WAKE_DUMMY: begin
        nxt_target = pc_ff + 16'h0001;
        nxt_state = ST_OPFETCH;
      end
      ST_OPFETCH: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // bus pattern of the next cycle, so the pins come from flip-flops
  always_comb begin
    nxt_addr = DUMMY_ADDR;
    nxt_rw = 1'b1;
    nxt_lir_n = 1'b1;
    nxt_dout = BYTE_RST;
    case (nxt_state)
      ST_FETCH1: begin
        nxt_addr = (state_ff == ST_IDLE) ? op_addr + 16'h0001 : pc_ff + 16'h0001;
      end
      ST_STACK: begin
        nxt_addr = sp_ff - {13'h0000, nxt_cnt};
        nxt_rw = 1'b0;
        nxt_dout = frame_byte(nxt_cnt, ret_addr, index_reg, acc_a, acc_b, flags);
      end
      ST_PULL: begin
        nxt_addr = sp_ff + 16'h0001 + {13'h0000, nxt_cnt};
      end
      ST_VEC_HI: begin
        nxt_addr = nxt_vec;
      end
      ST_VEC_LO: begin
        nxt_addr = vec_ff + 16'h0001;
      end
      ST_OPFETCH: begin
        nxt_addr = nxt_target;
        nxt_lir_n = 1'b0;
      end
      default: begin
        // idle, dummy, wait and sleep all park on the dummy pattern
        nxt_addr = DUMMY_ADDR;
      end
    endcase
  end

  // sequencer state
  always_ff @(posedge clk) begin
    if (clr) begin
      state_ff <= ST_IDLE;
      cnt_ff <= CNT_RST;
      target_ff <= WORD_RST;
      vec_ff <= WORD_RST;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      target_ff <= nxt_target;
      vec_ff <= nxt_vec;
    end
  end

  // instruction context, caught at issue
  always_ff @(posedge clk) begin
    if (clr) begin
      kind_ff <= OP_BRANCH;
      pc_ff <= WORD_RST;
      sp_ff <= WORD_RST;
      taken_ff <= 1'b0;
    end else if (state_ff == ST_IDLE && start) begin
      kind_ff <= sbs_op_t'(op_kind);
      pc_ff <= op_addr;
      sp_ff <= stack_ptr;
      taken_ff <= branch_taken;
    end
  end

  // bus pins; strobes follow direction except on parked cycles
  always_ff @(posedge clk) begin
    if (clr) begin
      addr_ff <= ADDR_RST;
      rw_ff <= 1'b1;
      rd_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
      opcode_fetch_n_ff <= 1'b1;
      dout_ff <= BYTE_RST;
    end else begin
      addr_ff <= nxt_addr;
      rw_ff <= nxt_rw;
      rd_n_ff <= ~nxt_rw | (nxt_state inside {ST_IDLE, ST_DUMMY, ST_WAIT_IRQ, ST_SLEEP, ST_WAKE_DUMMY});
      wr_n_ff <= nxt_rw;
      opcode_fetch_n_ff <= nxt_lir_n;
      dout_ff <= nxt_dout;
    end
  end

  // read data to the core; write-only registers give a fixed pattern
  always_ff @(posedge clk) begin
    if (clr) begin
      rd_data_ff <= BYTE_RST;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= rw_ff & ~rd_n_ff;
      if (rw_ff && !rd_n_ff) begin
        rd_data_ff <= rd_byte;
      end
    end
  end

  // status toward the core
  assign busy = (state_ff != ST_IDLE);
  assign done = (state_ff == ST_OPFETCH);
  assign waiting = (state_ff == ST_WAIT_IRQ); // halt must stay off meanwhile
  assign sleeping = (state_ff == ST_SLEEP);
endmodule : sbs_sequencer

//--- rtl/sbs_pkg.sv
// shared constants and types of the stack/branch bus sequencer
package sbs_pkg;
  // bus cycle addresses
  localparam logic [15:0] DUMMY_ADDR = 16'hffff; // internal cycle parks here
  localparam logic [15:0] TRAP_VEC_HI = 16'hfffa; // soft trap routine address, high byte
  localparam logic [15:0] TRAP_VEC_LO = 16'hfffb; // soft trap routine address, low byte
  // stack frame last byte indices and pull positions of the return address
  localparam logic [2:0] FULL_FRAME_LAST = 3'h6; // seven bytes, index 0..6
  localparam logic [2:0] SUB_FRAME_LAST = 3'h1; // return address only
  localparam logic [2:0] PULL_RET_HI_IDX = 3'h5; // pull index of return address high
  localparam logic [2:0] PULL_RET_LO_IDX = 3'h6; // pull index of return address low
  // fixed read-back of write-only registers
  localparam logic [7:0] WO_READ_VALUE = 8'hff;
  // reset values
  localparam logic [15:0] ADDR_RST = 16'hffff;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [2:0] CNT_RST = 3'h0;
  // timing: power-up hold of the clear pin, kept by the board
  localparam int CLK_HZ = 20_000_000;
  localparam int POWER_UP_HOLD_MS = 20;
  localparam longint POWER_UP_HOLD_CYCLES = (longint'(POWER_UP_HOLD_MS) * CLK_HZ) / 1000;
  // instruction groups handled here
  typedef enum logic [2:0] {
    OP_IDLE_IRQ = 3'b000, // idle_until_irq_op
    OP_RET_IRQ = 3'b001, // return_from_irq_op
    OP_SOFT_TRAP = 3'b010, // soft_trap_op
    OP_SLEEP = 3'b011, // sleep_op
    OP_BRANCH = 3'b100, // conditional branch
    OP_BR_SUB = 3'b101 // branch_to_sub_op
  } sbs_op_t;
  // sequencer states, one per step of the bus sequences; several steps share the read or the dummy pattern
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_FETCH1 = 4'b0001,
    ST_DUMMY = 4'b0010,
    ST_STACK = 4'b0011,
    ST_PULL = 4'b0100,
    ST_WAIT_IRQ = 4'b0101,
    ST_VEC_HI = 4'b0110,
    ST_VEC_LO = 4'b0111,
    ST_SLEEP = 4'b1000,
    ST_WAKE_DUMMY = 4'b1001,
    ST_OPFETCH = 4'b1010
  } sbs_state_t;
endpackage : sbs_pkg

//--- rtl/sbs_clear_sync.sv
// power-on clear synchroniser gated by oscillator start
`timescale 1ns/10ps
module sbs_clear_sync
  import sbs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // clear pin and oscillator state
  input wire logic power_on_clear_n,
  input wire logic osc_running,
  // internal clear, level
  output logic internal_clear
);
  logic meta_ff; // first stage, read only by sync_ff
  logic sync_ff; // second stage, safe to use
  // two-stage sampling of the clear pin on the internal clock
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
    end else begin
      meta_ff <= power_on_clear_n;
      sync_ff <= meta_ff;
    end
  end
  // a stopped oscillator cannot clear anything, so gate on it
  assign internal_clear = reset | (osc_running & ~sync_ff);
endmodule : sbs_clear_sync

//--- dv/sbs_mem_model.sv
// external memory and peripheral model
`timescale 1ns/10ps
module sbs_mem_model (
  // bus from the sequencer
  input wire logic clk,
  input wire logic [15:0] addr,
  input wire logic rd_n,
  // read answer
  output logic [7:0] data_in,
  output logic wo_hit
);
  logic [7:0] last_ff = 8'h5a; // last level on data lines
  // page zero holds write-only registers
  assign wo_hit = !rd_n && addr[15:8] == 8'h00;
  // released lines flip, so a stale value never matches
  assign data_in = rd_n ? ~last_ff : addr[7:0] ^ addr[15:8];
  // remember the driven level
  always_ff @(posedge clk) begin
    last_ff <= data_in;
  end
endmodule : sbs_mem_model

//--- dv/sbs_sequencer_asserts.sv
// bus cycle checker of the sequencer
`timescale 1ns/10ps
module sbs_asserts
  import sbs_pkg::*;
(
  // watched ports
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [2:0] op_kind,
  input wire logic [15:0] addr_ff,
  input wire logic rw_ff,
  input wire logic rd_n_ff,
  input wire logic wr_n_ff,
  input wire logic opcode_fetch_n_ff,
  input wire logic [7:0] rd_data_ff,
  input wire logic wo_hit,
  input wire logic busy,
  input wire logic done,
  input wire logic waiting,
  input wire logic irq_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire go = start && !busy; // accepted issue
  AST_WR: assert property (!rw_ff |-> rd_n_ff && !wr_n_ff) else $error("write strobes");
  AST_DUM: assert property (rd_n_ff && wr_n_ff |-> addr_ff == 16'hffff && rw_ff) else $error("dummy");
  AST_MK: assert property (!opcode_fetch_n_ff |-> done && rw_ff && !rd_n_ff) else $error("marker");
  AST_BR: assert property (go && op_kind == OP_BRANCH |=> !done [*2] ##1 done) else $error("branch");
  AST_BSR: assert property (go && op_kind == OP_BR_SUB |=> ##2 !rw_ff [*2] ##1 done) else $error("bsr");
  AST_RTI: assert property (go && op_kind == OP_RET_IRQ |=> ##2 !rd_n_ff [*7] ##1 done) else $error("rti");
  AST_SWI: assert property (go && op_kind == OP_SOFT_TRAP |=> ##2 !rw_ff [*7]
    ##1 addr_ff == 16'hfffa ##1 addr_ff == 16'hfffb ##1 done) else $error("trap");
  AST_WAI: assert property (go && op_kind == OP_IDLE_IRQ |=> ##2 !rw_ff [*7] ##1 waiting) else $error("wai");
  AST_HOLD: assert property (waiting && !irq_req |=> waiting) else $error("wait hold");
  AST_IRQ: assert property (waiting && irq_req |=> !rd_n_ff ##1 !rd_n_ff ##1 done) else $error("vector");
  AST_WO: assert property (!rd_n_ff && wo_hit |=> rd_data_ff == 8'hff) else $error("wo read");
endmodule : sbs_asserts
bind sbs_sequencer sbs_asserts u_sbs_asserts (.clk, .reset, .start, .op_kind, .addr_ff, .rw_ff, .rd_n_ff,
  .wr_n_ff, .opcode_fetch_n_ff, .rd_data_ff, .wo_hit, .busy, .done, .waiting, .irq_req);

//--- dv/test_stack_branch_bus_sequencer.sv
// self-checking bench of the bus sequencer
`timescale 1ns/10ps
module test_stack_branch_bus_sequencer;
  import sbs_pkg::*;
  logic clk = 0, reset = 1, poc_n = 1, osc = 1, start = 0, taken = 0, irq_req = 0, wake_req = 0;
  logic [2:0] kind = 0;
  logic [15:0] op = 0, sp = 0, ix = 16'ha1b2, vec = 0;
  logic [7:0] acc_a = 8'hc3, acc_b = 8'hd4, cc = 8'he5;
  logic [15:0] addr;
  logic [7:0] din, dout, rdat;
  logic wo, rw, rd_n, wr_n, mk_n, rv, busy, done, waiting, sleeping;
  int errors = 0, total_checks = 0;
  always #25 clk = ~clk;
  sbs_sequencer u_sbs_sequencer (.clk, .reset, .power_on_clear_n(poc_n), .osc_running(osc), .start,
    .op_kind(kind), .op_addr(op), .stack_ptr(sp), .branch_taken(taken), .index_reg(ix), .acc_a, .acc_b,
    .flags(cc), .irq_req, .irq_vector(vec), .wake_req, .data_in(din), .wo_hit(wo), .addr_ff(addr),
    .rw_ff(rw), .rd_n_ff(rd_n), .wr_n_ff(wr_n), .opcode_fetch_n_ff(mk_n), .dout_ff(dout),
    .rd_data_ff(rdat), .rd_valid_ff(rv), .busy, .done, .waiting, .sleeping);
  sbs_mem_model u_sbs_mem_model (.clk, .addr, .rd_n, .data_in(din), .wo_hit(wo));
  // compare and count
  task automatic chk(string what, logic [27:0] e, logic [27:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", what, e, g);
    end
  endtask : chk
  // one bus cycle: 0 read, 1 write, 2 dummy, 3 opcode fetch
  task automatic cyc(int t, logic [15:0] a, logic [7:0] d = 8'h00);
    logic [3:0] s;
    s = t == 0 ? 4'b1011 : t == 1 ? 4'b0101 : t == 2 ? 4'b1111 : 4'b1010;
    #1;
    chk("bus", {t == 2 ? 16'hffff : a, s, t == 1 ? d : BYTE_RST}, {addr, rw, rd_n, wr_n, mk_n, dout});
    if (t == 3) chk("done", 1'b1, done);
    @(posedge clk);
  endtask : cyc
  // issue pulse, taken at the second edge
  task automatic issue(logic [2:0] k, logic [15:0] o, logic [15:0] s);
    @(posedge clk);
    start <= 1;
    kind <= k;
    op <= o;
    sp <= s;
    @(posedge clk);
    start <= 0;
  endtask : issue
  // seven stacked bytes, top down
  task automatic push7(logic [15:0] r, logic [15:0] s);
    logic [7:0] v [7];
    v = '{r[7:0], r[15:8], ix[7:0], ix[15:8], acc_a, acc_b, cc};
    for (int i = 0; i < 7; i++) cyc(1, s - 16'(i), v[i]);
  endtask : push7
  // taken offset read from write-only page is ff, so target is op+1
  task automatic t_branch;
    taken <= 1;
    issue(OP_BRANCH, 16'h0040, 16'h0);
    cyc(0, 16'h0041);
    #1;
    chk("wo read", WO_READ_VALUE, rdat);
    chk("rd valid", 1'b1, rv);
    cyc(2, 0);
    cyc(3, 16'h0041);
    taken <= 0;
    issue(OP_BRANCH, 16'h1230, 16'h0);
    cyc(0, 16'h1231);
    #1;
    chk("rd data", 8'h23, rdat);
    cyc(2, 0);
    cyc(3, 16'h1232);
    $display("branch test done");
  endtask : t_branch
  task automatic t_bsr;
    issue(OP_BR_SUB, 16'h2000, 16'h3000);
    cyc(0, 16'h2001);
    cyc(2, 0);
    cyc(1, 16'h3000, 8'h02);
    cyc(1, 16'h2fff, 8'h20);
    cyc(3, 16'h2023);
    $display("bsr test done");
  endtask : t_bsr
  // no halt request is ever raised while waiting
  task automatic t_wai;
    issue(OP_IDLE_IRQ, 16'h4000, 16'h5000);
    cyc(0, 16'h4001);
    cyc(2, 0);
    push7(16'h4001, 16'h5000);
    repeat (3) begin
      #1;
      chk("waiting", 1'b1, waiting);
      cyc(2, 0);
    end
    vec <= 16'h6000;
    irq_req <= 1;
    @(posedge clk);
    irq_req <= 0;
    cyc(0, 16'h6000);
    cyc(0, 16'h6001);
    cyc(3, 16'h6061);
    $display("wai test done");
  endtask : t_wai
  task automatic t_swi;
    issue(OP_SOFT_TRAP, 16'h4100, 16'h5100);
    cyc(0, 16'h4101);
    cyc(2, 0);
    push7(16'h4101, 16'h5100);
    cyc(0, 16'hfffa);
    cyc(0, 16'hfffb);
    cyc(3, 16'h0504);
    $display("swi test done");
  endtask : t_swi
  task automatic t_rti;
    issue(OP_RET_IRQ, 16'h7000, 16'h7100);
    cyc(0, 16'h7001);
    cyc(2, 0);
    for (int i = 1; i < 8; i++) cyc(0, 16'h7100 + 16'(i));
    cyc(3, 16'h7776);
    $display("rti test done");
  endtask : t_rti
  task automatic t_sleep;
    issue(OP_SLEEP, 16'h8000, 16'h0);
    cyc(0, 16'h8001);
    cyc(2, 0);
    repeat (2) begin
      #1;
      chk("sleeping", 1'b1, sleeping);
      cyc(2, 0);
    end
    wake_req <= 1;
    @(posedge clk);
    wake_req <= 0;
    cyc(2, 0);
    cyc(3, 16'h8001);
    $display("sleep test done");
  endtask : t_sleep
  // clear pin is dead until the oscillator runs
  task automatic t_clear;
    issue(OP_SLEEP, 16'h8000, 16'h0);
    cyc(0, 16'h8001);
    osc <= 0;
    poc_n <= 0;
    repeat (4) @(posedge clk);
    #1;
    chk("no osc", 1'b1, sleeping);
    @(posedge clk);
    osc <= 1;
    repeat (4) @(posedge clk);
    #1;
    chk("cleared", {16'hffff, 1'b0}, {addr, busy});
    @(posedge clk);
    poc_n <= 1;
    repeat (3) @(posedge clk);
    // sequencer must run again once the clear has let go
    issue(OP_BRANCH, 16'h1230, 16'h0);
    cyc(0, 16'h1231);
    cyc(2, 0);
    cyc(3, 16'h1232);
    $display("clear test done");
  endtask : t_clear
  task automatic results;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  // short reset stands in for the board's power-up hold
  initial begin
    repeat (6) @(posedge clk);
    reset <= 0;
    t_branch;
    t_bsr;
    t_wai;
    t_swi;
    t_rti;
    t_sleep;
    t_clear;
    results;
  end
  // watchdog, far beyond the hundred or so cycles needed
  initial begin
    #200000;
    errors++;
    results;
  end
endmodule : test_stack_branch_bus_sequencer
